// [hw/bdcl_pkg.sv]
// Purpose: Shared constants and types of the debug command layer.
// Assumes: Target serial clock equals clk_sys (50 MHz, 20 ns).
// Notes:   All counts are in clk_sys cycles.
package bdcl_pkg;
  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_READ_NEXT = 8'h62;
  localparam logic [7:0] OP_WRITE_NEXT = 8'h42;
  localparam logic [7:0] OP_GO = 8'h08;
  localparam logic [7:0] OP_GO_UNTIL = 8'h0c;
  localparam logic [7:0] OP_SINGLE_STEP = 8'h10;
  localparam logic [7:0] OP_TAG_GO = 8'h18;
  localparam logic [7:0] OP_HW_RD_BYTE = 8'he0;
  localparam logic [7:0] OP_HW_RD_WORD = 8'he8;
  localparam logic [7:0] OP_HW_WR_BYTE = 8'hc0;
  localparam logic [7:0] OP_HW_WR_WORD = 8'hc8;
  // Low three opcode bits select the CPU register
  localparam logic [2:0] SEL_PC = 3'h3;
  localparam logic [2:0] SEL_D = 3'h4;
  localparam logic [2:0] SEL_X = 3'h5;
  localparam logic [2:0] SEL_Y = 3'h6;
  localparam logic [2:0] SEL_SP = 3'h7;
  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam logic [9:0] BIT_CYC = 10'h010;
  localparam logic [9:0] SAMPLE_CYC = 10'h00a;
  localparam logic [9:0] TX0_LOW_CYC = 10'h00d;
  localparam logic [9:0] TX1_SPEED_CYC = 10'h007;
  localparam logic [9:0] TIMEOUT_CYC = 10'h200;
  localparam logic [9:0] ACK_LOW_CYC = 10'h010;
  localparam logic [5:0] ACK_MIN_CYC = 6'h20;
  // Frame end is the 16th tick, six cycles after the last sample
  localparam logic [5:0] ACK_START_CYC =
    ACK_MIN_CYC + 6'(BIT_CYC - SAMPLE_CYC);
  localparam logic [7:0] FREE_WAIT_CYC = 8'h80;
  localparam logic [15:0] X_STEP = 16'h0002;
  localparam logic [7:0] MAP_HI = 8'hff;
  // Host side waits without acknowledge, for the bench
  localparam logic [7:0] HOST_HW_WAIT = 8'h96;
  localparam logic [7:0] HOST_FW_RD_WAIT = 8'h2c;
  localparam logic [7:0] HOST_FW_WR_WAIT = 8'h20;
  localparam logic [7:0] HOST_RUN_WAIT = 8'h40;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_OP = 3'b000, ST_ADR = 3'b001, ST_DAT = 3'b010,
    ST_EXEC = 3'b011, ST_ACK = 3'b100, ST_TX = 3'b101,
    ST_RUN = 3'b110
  } bdcl_state_t;

  typedef struct packed {
    bdcl_state_t st;
    logic [9:0] bcnt;
    logic [4:0] nbits;
    logic [7:0] op;
    logic [15:0] adr;
    logic [15:0] sh;
    logic s1, s2, s3;
    logic pin_o, pin_oe;
    logic [5:0] gap;
    logic sub, rd, ackp;
    logic [7:0] wcnt;
    logic req, issued, freeze, mwe, mbyte;
    logic [15:0] maddr;
    logic rwe;
    logic [2:0] rsel;
    logic [15:0] rdat;
    logic bg, tag, go, step;
  } bdcl_regs_t;
endpackage : bdcl_pkg

// [hw/bdcl_top.sv]
// Purpose: Command layer of the single-wire background debug port.
// Assumes: Serial bits are timed on clk_sys; CPU hooks are same clock.
// Notes:   Acknowledge enable comes from the hardware command layer.
// How it works
// - Firmware commands run only in debug state, else ignored.
// - Debug state maps firmware table at 0xFF00 to 0xFFFF.
// - Read-next adds 2 to X then reads word at new X.
// - Opcodes 63..67 return PC, D, X, Y, SP.
// - Write-next adds 2 to X then stores word at new X.
// - Opcodes 43..47 load PC, D, X, Y, SP.
// - Resume leaves debug state; acknowledge on leaving.
// - Resume-until runs; acknowledge on later re-entry.
// - Single step runs one instruction; acknowledge on re-entry.
// - Tag-and-resume enables tagging, resumes, never acknowledges.
// - Acknowledge reads when data ready, writes when done.
// - Frame is opcode, then address and/or data; reads give 16 bits.
// - Byte read: even byte high half, odd byte low half.
// - Word access ignores address bit zero.
// - No acknowledge while CPU waits with clocks off or stops.
// - Line idles high; each bit starts on a host falling edge.
// - Memory access waits 128 cycles for free bus, then steals.
// - Sixteen cycles per bit, MSB first; 512-cycle gap aborts.
// - Acknowledge is 16 low then one high, 32 after frame end.
`timescale 1ns/1ns
module bdcl_top (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic debug_serial_pin_i,
  output logic debug_serial_pin_o,
  output logic debug_serial_pin_oe,
  input wire logic ack_enable,
  input wire logic cpu_wait_stop,
  input wire logic debug_entry,
  input wire logic [15:0] cpu_addr,
  output logic fw_map_sel,
  output logic background_debug_state,
  input wire logic [15:0] cpu_pc,
  input wire logic [15:0] cpu_d,
  input wire logic [15:0] cpu_x,
  input wire logic [15:0] cpu_y,
  input wire logic [15:0] cpu_sp,
  output logic reg_we,
  output logic [2:0] reg_sel,
  output logic [15:0] reg_wdata,
  output logic go_req,
  output logic step_req,
  output logic tag_enable,
  input wire logic bus_free,
  output logic mem_stb,
  output logic mem_we,
  output logic mem_byte,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_done,
  output logic cpu_freeze
);
  import bdcl_pkg::*;

  // ****************************************************************
  // Opcode decoding
  // ****************************************************************
  // Opcode needs a 16-bit address phase
  function automatic logic op_has_adr(input logic [7:0] op);
    op_has_adr = (op == OP_HW_RD_BYTE) || (op == OP_HW_RD_WORD) ||
                 (op == OP_HW_WR_BYTE) || (op == OP_HW_WR_WORD);
  endfunction : op_has_adr

  // Opcode needs a 16-bit data phase
  function automatic logic op_has_dat(input logic [7:0] op);
    op_has_dat = (op[7:3] == 5'h08 && op[2:0] >= SEL_PC) ||
                 (op == OP_WRITE_NEXT) ||
                 (op == OP_HW_WR_BYTE) || (op == OP_HW_WR_WORD);
  endfunction : op_has_dat

  // Opcode is a firmware command
  function automatic logic op_is_fw(input logic [7:0] op);
    op_is_fw = (op[7:3] == 5'h0c) || (op[7:3] == 5'h08) ||
               (op == OP_GO) || (op == OP_GO_UNTIL) ||
               (op == OP_SINGLE_STEP) || (op == OP_TAG_GO);
  endfunction : op_is_fw

  bdcl_regs_t q, n;
  logic fall;
  logic fin;
  logic last;
  logic stb;

  // Falling edge seen on the synchronised line
  assign fall = q.s3 & ~q.s2;
  // Strobe on a free cycle, or a stolen one under freeze
  assign stb = q.req & ~q.issued & (bus_free | q.freeze);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = q;
    fin = 1'b0;
    last = 1'b0;
    n.s1 = debug_serial_pin_i;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.go = 1'b0;
    n.step = 1'b0;
    n.rwe = 1'b0;
    n.pin_oe = 1'b0;
    n.pin_o = 1'b1;
    if (q.gap != 6'h3f) begin
      n.gap = q.gap + 6'h01;
    end
    // Breakpoint, entry instruction or step end re-enter debug
    if (debug_entry) begin
      n.bg = 1'b1;
    end
    unique case (q.st)
      ST_OP, ST_ADR, ST_DAT: begin
        if (fall) begin
          n.bcnt = '0;
        end else if (q.bcnt != TIMEOUT_CYC) begin
          n.bcnt = q.bcnt + 10'h001;
        end
        last = (q.st == ST_OP) ? (q.nbits == 5'h07)
                               : (q.nbits == 5'h0f);
        // Abandon a half frame after a long silence
        if (!fall && q.bcnt == TIMEOUT_CYC - 10'h001 &&
            (q.st != ST_OP || q.nbits != 5'h00)) begin
          n.st = ST_OP;
          n.nbits = '0;
        end else if (!fall && q.bcnt == SAMPLE_CYC) begin
          n.sh = {q.sh[14:0], q.s2};
          n.nbits = q.nbits + 5'h01;
          if (last) begin
            n.nbits = '0;
            n.gap = '0;
            n.sub = 1'b0;
            if (q.st == ST_OP) begin
              n.op = n.sh[7:0];
              // Frame shape follows the opcode
              if (op_has_adr(n.sh[7:0])) begin
                n.st = ST_ADR;
              end else if (op_has_dat(n.sh[7:0])) begin
                n.st = ST_DAT;
              end else begin
                n.st = ST_EXEC;
              end
            end else if (q.st == ST_ADR) begin
              n.adr = n.sh;
              n.st = op_has_dat(q.op) ? ST_DAT : ST_EXEC;
            end else begin
              n.st = ST_EXEC;
            end
          end
        end
      end
      ST_EXEC: begin
        n.rd = 1'b0;
        if (op_is_fw(q.op) && !q.bg) begin
          n.st = ST_OP;
        end else if (q.op[7:3] == 5'h0c && q.op[2:0] >= SEL_PC) begin
          // Register read
          unique case (q.op[2:0])
            SEL_PC: n.sh = cpu_pc;
            SEL_D: n.sh = cpu_d;
            SEL_X: n.sh = cpu_x;
            SEL_Y: n.sh = cpu_y;
            default: n.sh = cpu_sp;
          endcase
          n.rd = 1'b1;
          fin = 1'b1;
        end else if (q.op[7:3] == 5'h08 && q.op[2:0] >= SEL_PC) begin
          // Register write
          n.rwe = 1'b1;
          n.rsel = q.op[2:0];
          n.rdat = q.sh;
          fin = 1'b1;
        end else if (q.op == OP_GO) begin
          n.bg = 1'b0;
          n.go = 1'b1;
          fin = 1'b1;
        end else if (q.op == OP_GO_UNTIL ||
                     q.op == OP_SINGLE_STEP) begin
          n.bg = 1'b0;
          n.go = (q.op == OP_GO_UNTIL);
          n.step = (q.op == OP_SINGLE_STEP);
          n.ackp = ack_enable & ~cpu_wait_stop;
          n.st = n.ackp ? ST_RUN : ST_OP;
        end else if (q.op == OP_TAG_GO) begin
          // Tagged resume never acknowledges
          n.bg = 1'b0;
          n.tag = 1'b1;
          n.go = 1'b1;
          n.st = ST_OP;
        end else if (op_is_fw(q.op) || op_has_adr(q.op)) begin
          // Opcode bit 5 set marks a read, both firmware and hardware
          n.rd = q.op[5];
          if (!q.sub) begin
            // Set up the access address
            n.sub = 1'b1;
            n.mwe = !n.rd;
            n.mbyte = (q.op == OP_HW_RD_BYTE) ||
                      (q.op == OP_HW_WR_BYTE);
            if (op_is_fw(q.op)) begin
              // Pointer steps before the access
              n.rwe = 1'b1;
              n.rsel = SEL_X;
              n.rdat = cpu_x + X_STEP;
              // Odd pointer still gives an even word access
              n.maddr = (cpu_x + X_STEP) & ~16'h0001;
            end else if (n.mbyte) begin
              n.maddr = q.adr;
            end else begin
              n.maddr = {q.adr[15:1], 1'b0};
            end
          end else if (!q.req) begin
            n.req = 1'b1;
            n.wcnt = '0;
          end else begin
            if (stb) begin
              n.issued = 1'b1;
            end
            // Out of patience: freeze and steal
            if (!q.issued && !q.freeze) begin
              n.wcnt = q.wcnt + 8'h01;
              if (q.wcnt == FREE_WAIT_CYC - 8'h01) begin
                n.freeze = 1'b1;
              end
            end
            if (mem_done && q.issued) begin
              n.req = 1'b0;
              n.issued = 1'b0;
              n.freeze = 1'b0;
              fin = 1'b1;
              if (!q.mbyte) begin
                n.sh = mem_rdata;
              end else if (q.maddr[0]) begin
                n.sh = {8'h00, mem_rdata[7:0]};
              end else begin
                n.sh = {mem_rdata[15:8], 8'h00};
              end
              if (q.mwe) begin
                n.sh = q.sh;
              end
            end
          end
        end else begin
          n.st = ST_OP;
        end
        // Acknowledge when data ready or write done
        if (fin) begin
          n.nbits = '0;
          n.bcnt = TIMEOUT_CYC;
          if (ack_enable && !cpu_wait_stop) begin
            n.st = ST_ACK;
            n.bcnt = '0;
          end else begin
            n.st = n.rd ? ST_TX : ST_OP;
          end
        end
      end
      ST_ACK: begin
        // Low pulse then one speedup cycle
        if (q.gap >= ACK_START_CYC) begin
          n.bcnt = q.bcnt + 10'h001;
          n.pin_oe = 1'b1;
          n.pin_o = (q.bcnt == ACK_LOW_CYC);
          if (q.bcnt == ACK_LOW_CYC) begin
            n.st = q.rd ? ST_TX : ST_OP;
            n.bcnt = TIMEOUT_CYC;
            n.rd = 1'b0;
          end
        end
      end
      ST_TX: begin
        if (fall) begin
          n.bcnt = '0;
        end else if (q.bcnt != TIMEOUT_CYC) begin
          n.bcnt = q.bcnt + 10'h001;
        end
        // Zero: drive low then speed up; one: speedup pulse only
        if (q.sh[15]) begin
          n.pin_oe = (n.bcnt == TX1_SPEED_CYC);
        end else begin
          n.pin_oe = (n.bcnt <= TX0_LOW_CYC);
          n.pin_o = (n.bcnt == TX0_LOW_CYC);
        end
        if (!fall && q.bcnt == TIMEOUT_CYC - 10'h001 &&
            q.nbits != 5'h00) begin
          n.st = ST_OP;
          n.nbits = '0;
        end else if (!fall && q.bcnt == BIT_CYC - 10'h001) begin
          n.sh = {q.sh[14:0], 1'b0};
          n.nbits = q.nbits + 5'h01;
          if (q.nbits == 5'h0f) begin
            n.st = ST_OP;
            n.nbits = '0;
          end
        end
      end
      ST_RUN: begin
        // Wait or stop cancels the pending acknowledge
        if (cpu_wait_stop) begin
          n.ackp = 1'b0;
        end
        if (debug_entry) begin
          n.st = (q.ackp && !cpu_wait_stop) ? ST_ACK : ST_OP;
          n.bcnt = '0;
          n.ackp = 1'b0;
          n.rd = 1'b0;
        end
      end
      default: begin
        n.st = ST_OP;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Line assumed idle high out of reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      q <= '0;
      q.bcnt <= TIMEOUT_CYC;
      q.s1 <= 1'b1;
      q.s2 <= 1'b1;
      q.s3 <= 1'b1;
      q.pin_o <= 1'b1;
      q.gap <= 6'h3f;
    end else begin
      q <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign debug_serial_pin_o = q.pin_o;
  assign debug_serial_pin_oe = q.pin_oe;
  assign background_debug_state = q.bg;
  // Firmware table overlays the top page only in debug state
  assign fw_map_sel = q.bg & (cpu_addr[15:8] == MAP_HI);
  assign reg_we = q.rwe;
  assign reg_sel = q.rsel;
  assign reg_wdata = q.rdat;
  assign go_req = q.go;
  assign step_req = q.step;
  assign tag_enable = q.tag;
  assign mem_stb = stb;
  assign mem_we = q.mwe;
  assign mem_byte = q.mbyte;
  assign mem_addr = q.maddr;
  assign mem_wdata = q.sh;
  assign cpu_freeze = q.freeze;
endmodule : bdcl_top

// [tb/bdcl_chk.sv]
// Purpose: Port checker for the debug command layer.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to every bdcl_top instance.
`timescale 1ns/1ns
module bdcl_chk
  import bdcl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic debug_serial_pin_o,
  input wire logic debug_serial_pin_oe,
  input wire logic [15:0] cpu_addr,
  input wire logic fw_map_sel,
  input wire logic background_debug_state,
  input wire logic reg_we,
  input wire logic go_req,
  input wire logic step_req,
  input wire logic bus_free,
  input wire logic mem_stb,
  input wire logic mem_byte,
  input wire logic [15:0] mem_addr,
  input wire logic cpu_freeze
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic drv_low;
  logic [4:0] run_q;
  // Device pulling the line low
  assign drv_low = debug_serial_pin_oe && !debug_serial_pin_o;
  // Length of each low stretch; saturates so it cannot wrap
  always_ff @(posedge clk_sys) begin
    if (!rstn || !drv_low) begin
      run_q <= 5'h00;
    end else if (run_q != 5'h1f) begin
      run_q <= run_q + 5'h01;
    end
  end
  sequence s_low_end;
    drv_low ##1 !drv_low;
  endsequence
  a_low_length: assert property ($fell(drv_low) |->
    run_q == 5'h0d || run_q == 5'h10) else $error("bad low length");
  a_low_speedup: assert property (s_low_end |->
    debug_serial_pin_oe && debug_serial_pin_o) else $error("no speedup");
  a_high_brief: assert property (
    debug_serial_pin_oe && debug_serial_pin_o |=> !debug_serial_pin_oe)
    else $error("high drive too long");
  a_map_decode: assert property (fw_map_sel ==
    (background_debug_state && cpu_addr[15:8] == MAP_HI))
    else $error("map select wrong");
  a_fw_in_dbg: assert property (reg_we |-> background_debug_state)
    else $error("register write outside debug");
  a_go_leaves: assert property (go_req |=> !background_debug_state)
    else $error("resume kept debug state");
  a_step_from_dbg: assert property (step_req |->
    !go_req && $past(background_debug_state)) else $error("bad step");
  a_steal_only: assert property (mem_stb |-> bus_free || cpu_freeze)
    else $error("access on busy bus");
  a_word_even: assert property (mem_stb && !mem_byte |-> !mem_addr[0])
    else $error("odd word address");
endmodule : bdcl_chk

bind bdcl_top bdcl_chk u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .cpu_addr(cpu_addr),
  .debug_serial_pin_o(debug_serial_pin_o),
  .debug_serial_pin_oe(debug_serial_pin_oe), .fw_map_sel(fw_map_sel),
  .background_debug_state(background_debug_state), .reg_we(reg_we),
  .go_req(go_req), .step_req(step_req), .bus_free(bus_free),
  .mem_stb(mem_stb), .mem_byte(mem_byte), .mem_addr(mem_addr),
  .cpu_freeze(cpu_freeze)
);

// [tb/bdcl_host.sv]
// Purpose: Debug pod model on the single-wire link.
// Assumes: Line is pulled up; the pod only ever pulls low.
// Notes:   20-clock bit period, slower than the device minimum.
`timescale 1ns/1ns
module bdcl_host (
  input wire logic clk_sys,
  input wire logic line,
  output logic host_low
);
  // ****************************************************************
  // Bit and frame tasks
  // ****************************************************************
  initial host_low = 1'b0;
  // Short low is a one, long low a zero; idle leaves line high
  task automatic bit_out(input logic b);
    host_low <= 1'b1;
    repeat (b ? 4 : 16) @(posedge clk_sys);
    host_low <= 1'b0;
    repeat (b ? 16 : 4) @(posedge clk_sys);
  endtask : bit_out
  task automatic send_op(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
  endtask : send_op
  task automatic send_word(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) bit_out(v[i]);
  endtask : send_word
  // Start each bit, release, sample mid-bit away from the edge
  task automatic recv(output logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      host_low <= 1'b1;
      repeat (2) @(posedge clk_sys);
      host_low <= 1'b0;
      repeat (9) @(posedge clk_sys);
      @(negedge clk_sys);
      v[i] = line;
      repeat (9) @(posedge clk_sys);
    end
  endtask : recv
  // Bounded watch for the device's low pulse, then its release
  task automatic wait_ack(input int lim, output logic got);
    int n;
    got = 1'b0;
    n = 0;
    while (!got && n < lim) begin
      @(negedge clk_sys);
      got = !line;
      n++;
    end
    n = 0;
    while (got && !line && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
  endtask : wait_ack
  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : pause
endmodule : bdcl_host

// [tb/bdcl_tb_top.sv]
// Purpose: Self-checking bench for the debug command layer.
// Assumes: Pod model drives the link; memory answers one clock later.
// Notes:   CPU registers are bench-held values, not a core model.
`timescale 1ns/1ns
module bdcl_tb_top;
  import bdcl_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam int CYC_MAX = 40000;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ack_enable = 1'b0;
  logic cpu_wait_stop = 1'b0;
  logic debug_entry = 1'b0;
  logic bus_free = 1'b1;
  logic mem_done = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [15:0] mem_rdata = 16'h0000;
  logic [15:0] rv [3:7] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'h0ff0};
  logic pin_o, pin_oe, host_low, fw_map_sel, dbg_st, reg_we, go_req;
  logic step_req, tag_enable, mem_stb, mem_we, mem_byte, cpu_freeze;
  logic [2:0] reg_sel, we_sel;
  logic [15:0] reg_wdata, mem_addr, mem_wdata, we_dat, sb_adr, sb_wd;
  logic sb_we, sb_frz;
  int we_n = 0, go_n = 0, st_n = 0, cyc = 0, bad_count = 0, comparisons = 0;
  // Pull-up resolves the open-drain line
  wire line = ~(host_low | (pin_oe & ~pin_o));

  bdcl_top uut (
    .clk_sys(clk_sys), .rstn(rstn), .debug_serial_pin_i(line),
    .debug_serial_pin_o(pin_o), .debug_serial_pin_oe(pin_oe),
    .ack_enable(ack_enable), .cpu_wait_stop(cpu_wait_stop),
    .debug_entry(debug_entry), .cpu_addr(cpu_addr),
    .fw_map_sel(fw_map_sel), .background_debug_state(dbg_st),
    .cpu_pc(rv[3]), .cpu_d(rv[4]), .cpu_x(rv[5]), .cpu_y(rv[6]),
    .cpu_sp(rv[7]), .reg_we(reg_we), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .go_req(go_req), .step_req(step_req),
    .tag_enable(tag_enable), .bus_free(bus_free), .mem_stb(mem_stb),
    .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_done(mem_done),
    .cpu_freeze(cpu_freeze)
  );
  bdcl_host pod (.clk_sys(clk_sys), .line(line), .host_low(host_low));

  // Memory contents depend on the word address only
  function automatic logic [15:0] mem_word(input logic [15:0] a);
    return {a[15:1], 1'b0} ^ 16'h5aa5;
  endfunction : mem_word

  initial forever #10 clk_sys = ~clk_sys;

  // Memory partner, port monitor and hang guard
  always @(posedge clk_sys) begin
    cyc++;
    mem_done <= mem_stb;
    mem_rdata <= mem_stb ? mem_word(mem_addr) : ~mem_rdata;
    we_n += reg_we;
    go_n += go_req;
    st_n += step_req;
    if (reg_we) begin
      we_sel <= reg_sel;
      we_dat <= reg_wdata;
    end
    if (mem_stb) begin
      sb_adr <= mem_addr;
      sb_wd <= mem_wdata;
      sb_we <= mem_we;
      sb_frz <= cpu_freeze;
    end
    if (cyc == CYC_MAX) begin
      bad_count++;
      $display("ERROR %0t: run did not finish", $time);
      complete_run();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input string m);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk
  task automatic enter();
    debug_entry <= 1'b1;
    @(posedge clk_sys);
    debug_entry <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : enter
  task automatic hw_rd(input logic [7:0] op, input logic [15:0] a,
                       output logic [15:0] v);
    logic got;
    pod.send_op(op);
    pod.send_word(a);
    pod.wait_ack(400, got);
    chk(16'(got), 16'h0001, "memory read ack");
    pod.recv(v);
  endtask : hw_rd
  task automatic run_cmd(input logic [7:0] op, input logic a1,
                         input logic a2, input logic ws);
    logic got;
    pod.send_op(op);
    pod.wait_ack(120, got);
    chk(16'(got), 16'(a1), "ack after command");
    cpu_wait_stop <= ws;
    pod.pause(HOST_RUN_WAIT);
    enter();
    cpu_wait_stop <= 1'b0;
    pod.wait_ack(120, got);
    chk(16'(got), 16'(a2), "ack on return");
  endtask : run_cmd

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_refuse();
    chk(16'({pin_oe, pin_o, dbg_st, tag_enable}), 16'h0004, "reset");
    pod.send_op(8'h45);
    pod.send_word(16'hbeef);
    pod.pause(HOST_FW_WR_WAIT);
    chk(16'(we_n), 16'h0000, "write outside debug");
    enter();
    cpu_addr <= 16'hff00;
    @(negedge clk_sys);
    chk(16'({dbg_st, fw_map_sel}), 16'h0003, "map in");
    @(posedge clk_sys);
    cpu_addr <= 16'hfeff;
    @(negedge clk_sys);
    chk(16'(fw_map_sel), 16'h0000, "map edge");
  endtask : t_refuse
  task automatic t_regs();
    logic [15:0] v;
    logic got;
    for (int i = 0; i < 4; i++) pod.bit_out(1'b0);
    pod.pause(600);
    for (int i = 3; i < 8; i++) begin
      pod.send_op(8'h40 + 8'(i));
      pod.send_word(16'h1000 + 16'(i));
      pod.pause(HOST_FW_WR_WAIT);
      chk(16'(we_sel), 16'(i), "write select");
      chk(we_dat, 16'h1000 + 16'(i), "write data");
    end
    chk(16'(we_n), 16'h0005, "write count");
    pod.send_op(8'h64);
    pod.pause(HOST_FW_RD_WAIT);
    pod.recv(v);
    chk(v, rv[4], "read without ack");
    ack_enable <= 1'b1;
    rv <= '{16'h2345, 16'h6789, 16'habcd, 16'hef01, 16'h1ff1};
    for (int i = 3; i < 8; i++) begin
      pod.send_op(8'h60 + 8'(i));
      pod.wait_ack(200, got);
      chk(16'(got), 16'h0001, "read ack");
      pod.recv(v);
      chk(v, rv[i], "register read");
    end
  endtask : t_regs
  task automatic t_next();
    logic [15:0] v;
    logic got;
    rv[5] <= 16'h2000;
    pod.send_op(OP_READ_NEXT);
    pod.wait_ack(200, got);
    pod.recv(v);
    chk(16'({we_sel, got}), 16'h000b, "pointer select");
    chk(we_dat, 16'h2002, "pointer step");
    chk(sb_adr, 16'h2002, "next address");
    chk(v, mem_word(16'h2002), "next data");
    rv[5] <= 16'h2101;
    pod.send_op(OP_WRITE_NEXT);
    pod.send_word(16'hc0de);
    pod.wait_ack(200, got);
    chk(16'({got, sb_we}), 16'h0003, "next write done");
    chk(sb_wd, 16'hc0de, "next write data");
    chk(sb_adr, 16'h2102, "next write align");
  endtask : t_next
  task automatic t_hw();
    logic [15:0] v;
    logic [15:0] w;
    w = mem_word(16'h3004);
    bus_free <= 1'b0;
    hw_rd(OP_HW_RD_BYTE, 16'h3005, v);
    chk(v, {8'h00, w[7:0]}, "odd byte");
    chk(16'(sb_frz), 16'h0001, "stolen cycle");
    bus_free <= 1'b1;
    hw_rd(OP_HW_RD_BYTE, 16'h3004, v);
    chk(v, {w[15:8], 8'h00}, "even byte");
    hw_rd(OP_HW_RD_WORD, 16'h3007, v);
    chk(sb_adr, 16'h3006, "word align");
    chk(v, w ^ 16'h0000 ^ mem_word(16'h3006) ^ w, "word data");
    chk(16'(sb_frz), 16'h0000, "free cycle used");
    // Word write with no acknowledge: host relies on the fixed wait
    ack_enable <= 1'b0;
    pod.send_op(OP_HW_WR_WORD);
    pod.send_word(16'h4001);
    pod.send_word(16'ha55a);
    pod.pause(HOST_HW_WAIT);
    chk({sb_adr[15:1], sb_we}, 16'h4001, "hw write");
    chk(sb_wd, 16'ha55a, "hw write data");
    ack_enable <= 1'b1;
  endtask : t_hw
  task automatic t_run();
    run_cmd(OP_GO, 1'b1, 1'b0, 1'b0);
    run_cmd(OP_GO_UNTIL, 1'b0, 1'b1, 1'b0);
    run_cmd(OP_SINGLE_STEP, 1'b0, 1'b1, 1'b0);
    run_cmd(OP_TAG_GO, 1'b0, 1'b0, 1'b0);
    run_cmd(OP_GO_UNTIL, 1'b0, 1'b0, 1'b1);
    chk(16'({go_n[3:0], st_n[3:0]}), 16'h0041, "run requests");
    chk(16'(tag_enable), 16'h0001, "tagging on");
  endtask : t_run

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_refuse();
    t_regs();
    t_next();
    t_hw();
    t_run();
    complete_run();
  end
endmodule : bdcl_tb_top
